//--- tbog_consts.vh
`ifndef TBOG_CONSTS_VH
`define TBOG_CONSTS_VH
`define TBOG_ADDR_CCER 8'h20
`define TBOG_ADDR_CNT 8'h24
`define TBOG_ADDR_PSC 8'h28
`define TBOG_ADDR_ARR 8'h2C
`define TBOG_ADDR_RCR 8'h30
`define TBOG_ADDR_CTRL 8'h48
`define TBOG_ADDR_GATE 8'h4C
`define TBOG_ADDR_STAT 8'h50
`define TBOG_RST_16 16'h0000
`define TBOG_RST_8 8'h00
`define TBOG_CTRL_EN 0
`define TBOG_CTRL_CMS 1
`define TBOG_CTRL_ARPE 2
`define TBOG_CTRL_PRELOAD 3
`define TBOG_CTRL_FORCE_UPD 4
`define TBOG_CTRL_COMMUTE 5
`define TBOG_GATE_MOE 0
`define TBOG_GATE_IDLE_OFFSTATE_SELECT 1
`define TBOG_GATE_RUN_OFFSTATE_SELECT 2
`define TBOG_GATE_IDLE_MAIN 3
`define TBOG_GATE_IDLE_COMPL 4
`define TBOG_GATE_INPUT_MODE 5
`define TBOG_GATE_DT 15:8
`define TBOG_CCER_CE 0
`define TBOG_CCER_CP 1
`define TBOG_CCER_NE 2
`define TBOG_CCER_NP 3
`endif

//--- tbog_timer.v
// Behaviour
// R1 - in input mode the channel enable allows or blocks counter capture
// R2 - channel enable bits preloaded; with preload select, copy only on commutation
// R3 - gate on, run off-state clear, both off: both undriven at zero
// R4 - gate on, one enabled: that output is reference xor polarity, driven
// R5 - gate on, both enabled: complementary pair with polarity and dead-time, driven
// R6 - gate on, run off-state set: disabled output driven at its polarity level (here only while the other output is enabled; both disabled stay undriven)
// R7 - gate off, enabled: polarity levels at once, then idle levels after dead-time
// R8 - software keeps idle and polarity bits clear when channel fully disabled
// R9 - 16-bit read/write counter value register, reset zero
// R10 - counter tick equals input clock divided by prescale value plus one
// R11 - prescale value reaches active prescaler only at update events
// R12 - counter held while reload value is zero
// R13 - repeat register keeps 8-bit repeat value, upper byte reserved
// R14 - software writes reserved upper byte of repeat register as zero
// R15 - repeat downcounter at zero gives update event and reloads
// R16 - repeat value write takes effect only at next repetition update
// R17 - repetition sets transfer rate and update interrupt rate
// R18 - repeat plus one counts full periods, or half periods when centered
// R19 - break input clears main output gate asynchronously
// R20 - counter advances each tick and flags overflow or underflow
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tbog_consts.vh"
module tbog_timer (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire [7:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire COMPARE_REFERENCE,
  input wire CAPTURE_IN,
  input wire BREAK_N,
  output reg OC_MAIN,
  output reg OC_MAIN_OE,
  output reg OC_COMPL,
  output reg OC_COMPL_OE,
  output reg REPEAT_UPDATE_EVENT,
  output reg [15:0] CAPTURE_VALUE
);
  reg [15:0] counter_value_ff;
  reg [15:0] prescale_value_ff;
  reg [15:0] active_prescale_ff;
  reg [15:0] prescale_cnt_ff;
  reg [15:0] reload_value_ff;
  reg [15:0] active_reload_ff;
  reg [7:0] repeat_value_ff;
  reg [7:0] repeat_downcounter_ff;
  reg [3:0] ccer_pre_ff;
  reg [3:0] ccer_act_ff;
  reg [5:0] ctrl_ff;
  reg [5:0] gate_ff;
  reg [7:0] dead_time_ff;
  reg [7:0] dt_cnt_ff;
  reg down_ff;
  reg main_output_gate_ff;
  reg ref_q_ff;
  reg [7:0] edge_dt_ff;
  reg [15:0] nxt_counter_value;
  reg nxt_ovf;
  wire wr_cnt = WR && (ADDR == `TBOG_ADDR_CNT);
  wire wr_gate = WR && (ADDR == `TBOG_ADDR_GATE);
  wire force_upd = WR && (ADDR == `TBOG_ADDR_CTRL) && WDATA[`TBOG_CTRL_FORCE_UPD];
  wire commute = WR && (ADDR == `TBOG_ADDR_CTRL) && WDATA[`TBOG_CTRL_COMMUTE];
  wire counter_tick = ctrl_ff[`TBOG_CTRL_EN] && (prescale_cnt_ff == active_prescale_ff); // R10
  wire run = counter_tick && (active_reload_ff != `TBOG_RST_16); // R12
  wire ovf_event = run && nxt_ovf; // R20
  wire repeat_update_event = force_upd || (ovf_event && (repeat_downcounter_ff == `TBOG_RST_8)); // R15
  wire channel_output_enable = ccer_act_ff[`TBOG_CCER_CE];
  wire compl_output_enable = ccer_act_ff[`TBOG_CCER_NE];
  wire channel_polarity = ccer_act_ff[`TBOG_CCER_CP];
  wire compl_polarity = ccer_act_ff[`TBOG_CCER_NP];
  wire idle_offstate_select = gate_ff[`TBOG_GATE_IDLE_OFFSTATE_SELECT];
  wire run_offstate_select = gate_ff[`TBOG_GATE_RUN_OFFSTATE_SELECT];
  wire dt_done = (dt_cnt_ff == dead_time_ff);
  wire main_on = ref_q_ff && (edge_dt_ff == dead_time_ff);
  wire compl_on = !ref_q_ff && (edge_dt_ff == dead_time_ff);

  // saturating step shared by both dead-time counters
  function [7:0] sat_inc;
    input [7:0] v;
    input [7:0] lim;
    begin
      sat_inc = (v == lim) ? v : v + 8'h01;
    end
  endfunction

  // next counter value; edge mode counts up, center mode up then down
  always @*
  begin
    nxt_counter_value = counter_value_ff;
    nxt_ovf = 1'b0;
    if (!ctrl_ff[`TBOG_CTRL_CMS])
    begin
      if (counter_value_ff >= active_reload_ff)
      begin
        nxt_counter_value = `TBOG_RST_16;
        nxt_ovf = 1'b1; // R18
      end
      else
        nxt_counter_value = counter_value_ff + 16'h0001;
    end
    else if (!down_ff)
    begin
      nxt_counter_value = counter_value_ff + 16'h0001;
      if (counter_value_ff + 16'h0001 >= active_reload_ff)
        nxt_ovf = 1'b1; // R18
    end
    else
    begin
      nxt_counter_value = counter_value_ff - 16'h0001;
      if (counter_value_ff <= 16'h0001)
        nxt_ovf = 1'b1; // R18
    end
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      counter_value_ff <= `TBOG_RST_16;
      prescale_value_ff <= `TBOG_RST_16;
      active_prescale_ff <= `TBOG_RST_16;
      prescale_cnt_ff <= `TBOG_RST_16;
      reload_value_ff <= `TBOG_RST_16;
      active_reload_ff <= `TBOG_RST_16;
      repeat_value_ff <= `TBOG_RST_8;
      repeat_downcounter_ff <= `TBOG_RST_8;
      ccer_pre_ff <= 4'h0;
      ccer_act_ff <= 4'h0;
      ctrl_ff <= 6'h00;
      gate_ff <= 6'h00;
      dead_time_ff <= `TBOG_RST_8;
      down_ff <= 1'b0;
      REPEAT_UPDATE_EVENT <= 1'b0;
      CAPTURE_VALUE <= `TBOG_RST_16;
      RDATA <= `TBOG_RST_16;
    end
    else if (CE)
    begin
      REPEAT_UPDATE_EVENT <= repeat_update_event;
      if (WR)
      begin
        case (ADDR)
          `TBOG_ADDR_CCER: ccer_pre_ff <= WDATA[3:0];
          `TBOG_ADDR_PSC: prescale_value_ff <= WDATA;
          `TBOG_ADDR_ARR: reload_value_ff <= WDATA;
          `TBOG_ADDR_RCR: repeat_value_ff <= WDATA[7:0]; // R13
          `TBOG_ADDR_CTRL: ctrl_ff <= {2'b00, WDATA[3:0]};
          `TBOG_ADDR_GATE:
          begin
            gate_ff <= {WDATA[5:1], 1'b0};
            dead_time_ff <= WDATA[`TBOG_GATE_DT];
          end
          default: ;
        endcase
      end
      // R2
      if (!ctrl_ff[`TBOG_CTRL_PRELOAD])
        ccer_act_ff <= (WR && ADDR == `TBOG_ADDR_CCER) ? WDATA[3:0] : ccer_pre_ff;
      else if (commute)
        ccer_act_ff <= ccer_pre_ff; // R2
      if (!ctrl_ff[`TBOG_CTRL_ARPE])
        active_reload_ff <= reload_value_ff;
      // prescaler divider
      if (force_upd || counter_tick || !ctrl_ff[`TBOG_CTRL_EN])
        prescale_cnt_ff <= `TBOG_RST_16;
      else
        prescale_cnt_ff <= prescale_cnt_ff + 16'h0001; // R10
      if (wr_cnt)
        counter_value_ff <= WDATA; // R9
      else if (force_upd)
      begin
        counter_value_ff <= `TBOG_RST_16;
        down_ff <= 1'b0;
      end
      else if (run)
      begin
        counter_value_ff <= nxt_counter_value; // R20
        if (ctrl_ff[`TBOG_CTRL_CMS] && nxt_ovf)
          down_ff <= !down_ff;
      end
      // prescale and, with ARPE set, reload transfers wait for the repetition update, not every overflow
      if (repeat_update_event)
      begin
        active_prescale_ff <= prescale_value_ff; // R11
        active_reload_ff <= reload_value_ff;
      end
      if (repeat_update_event)
        repeat_downcounter_ff <= repeat_value_ff; // R16
      else if (ovf_event)
        repeat_downcounter_ff <= repeat_downcounter_ff - 8'h01; // R17
      if (gate_ff[`TBOG_GATE_INPUT_MODE] && channel_output_enable && CAPTURE_IN)
        CAPTURE_VALUE <= counter_value_ff; // R1
      if (RD)
      begin
        case (ADDR)
          `TBOG_ADDR_CCER: RDATA <= {12'h000, ccer_pre_ff};
          `TBOG_ADDR_CNT: RDATA <= counter_value_ff;
          `TBOG_ADDR_PSC: RDATA <= prescale_value_ff;
          `TBOG_ADDR_ARR: RDATA <= reload_value_ff;
          `TBOG_ADDR_RCR: RDATA <= {8'h00, repeat_value_ff};
          `TBOG_ADDR_CTRL: RDATA <= {10'h000, ctrl_ff};
          `TBOG_ADDR_GATE: RDATA <= {dead_time_ff, 2'b00, gate_ff[5:1], main_output_gate_ff};
          `TBOG_ADDR_STAT: RDATA <= {7'h00, down_ff, repeat_downcounter_ff};
          default: RDATA <= `TBOG_RST_16;
        endcase
      end
    end
  end

  // main output gate: break clears at once, software sets
  always @(posedge CLK or negedge BREAK_N or negedge RST_N)
  begin
    if (!RST_N)
      main_output_gate_ff <= 1'b0;
    else if (!BREAK_N)
      main_output_gate_ff <= 1'b0; // R19
    else if (CE && wr_gate)
      main_output_gate_ff <= WDATA[`TBOG_GATE_MOE];
  end

  // dead-time counters: idle settle and reference edge
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dt_cnt_ff <= `TBOG_RST_8;
      edge_dt_ff <= `TBOG_RST_8;
      ref_q_ff <= 1'b0;
    end
    else if (CE)
    begin
      ref_q_ff <= COMPARE_REFERENCE;
      if (ref_q_ff != COMPARE_REFERENCE)
        edge_dt_ff <= `TBOG_RST_8;
      else
        edge_dt_ff <= sat_inc(edge_dt_ff, dead_time_ff); // R5
      if (main_output_gate_ff)
        dt_cnt_ff <= `TBOG_RST_8;
      else
        dt_cnt_ff <= sat_inc(dt_cnt_ff, dead_time_ff); // R7
    end
  end

  // output gating, registered
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      OC_MAIN <= 1'b0;
      OC_MAIN_OE <= 1'b0;
      OC_COMPL <= 1'b0;
      OC_COMPL_OE <= 1'b0;
    end
    else if (!CE)
    begin
      // clock enable low: pins keep their last state
      OC_MAIN <= OC_MAIN;
      OC_MAIN_OE <= OC_MAIN_OE;
      OC_COMPL <= OC_COMPL;
      OC_COMPL_OE <= OC_COMPL_OE;
    end
    else if (gate_ff[`TBOG_GATE_INPUT_MODE])
    begin
      OC_MAIN <= 1'b0;
      OC_MAIN_OE <= 1'b0;
      OC_COMPL <= 1'b0;
      OC_COMPL_OE <= 1'b0;
    end
    else if (!main_output_gate_ff)
    begin
      if (channel_output_enable || compl_output_enable)
      begin
        OC_MAIN <= dt_done ? gate_ff[`TBOG_GATE_IDLE_MAIN] : channel_polarity; // R7
        OC_COMPL <= dt_done ? gate_ff[`TBOG_GATE_IDLE_COMPL] : compl_polarity; // R7
        OC_MAIN_OE <= idle_offstate_select; // R7
        OC_COMPL_OE <= idle_offstate_select; // R7
      end
      else
      begin
        OC_MAIN <= channel_polarity;
        OC_COMPL <= compl_polarity;
        OC_MAIN_OE <= 1'b0;
        OC_COMPL_OE <= 1'b0;
      end
    end
    else if (channel_output_enable && compl_output_enable)
    begin
      OC_MAIN <= main_on ^ channel_polarity; // R5
      OC_COMPL <= compl_on ^ compl_polarity; // R5
      OC_MAIN_OE <= 1'b1;
      OC_COMPL_OE <= 1'b1;
    end
    else if (channel_output_enable || compl_output_enable)
    begin
      OC_MAIN <= channel_output_enable ? (COMPARE_REFERENCE ^ channel_polarity)
        : (run_offstate_select ? channel_polarity : 1'b0); // R4 R6
      OC_COMPL <= compl_output_enable ? (COMPARE_REFERENCE ^ compl_polarity)
        : (run_offstate_select ? compl_polarity : 1'b0); // R4 R6
      OC_MAIN_OE <= channel_output_enable || run_offstate_select; // R4 R6
      OC_COMPL_OE <= compl_output_enable || run_offstate_select; // R4 R6
    end
    else
    begin
      OC_MAIN <= run_offstate_select ? channel_polarity : 1'b0; // R3 R6
      OC_COMPL <= run_offstate_select ? compl_polarity : 1'b0; // R3 R6
      OC_MAIN_OE <= 1'b0; // R3
      OC_COMPL_OE <= 1'b0; // R3
    end
  end
endmodule // tbog_timer
`default_nettype wire

//--- tbog_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbog_switch_model (
  input wire logic hi_lvl,
  input wire logic hi_oe,
  input wire logic lo_lvl,
  input wire logic lo_oe,
  output logic hi_gate,
  output logic lo_gate
);
  // a pin the timer leaves undriven is pulled low at the switch gate
  assign hi_gate = hi_oe ? hi_lvl : 1'b0;
  assign lo_gate = lo_oe ? lo_lvl : 1'b0;
endmodule // tbog_switch_model
`default_nettype wire

//--- tbog_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbog_consts.vh"
module tbog_timer_assertions (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire [7:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire COMPARE_REFERENCE,
  input wire CAPTURE_IN,
  input wire BREAK_N,
  input wire OC_MAIN,
  input wire OC_MAIN_OE,
  input wire OC_COMPL,
  input wire OC_COMPL_OE,
  input wire REPEAT_UPDATE_EVENT,
  input wire [15:0] CAPTURE_VALUE
);
  reg [15:0] g_ff;
  reg [3:0] c_ff;
  reg p_ff;
  // shadow of gate and enable bits; only trusted while the preload select is off
  wire ok = CE && !p_ff && !g_ff[5] && g_ff[15:8] == 8'h00;
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      g_ff <= 16'h0000;
      c_ff <= 4'h0;
      p_ff <= 1'b0;
    end
    else
    begin
      if (CE && WR && ADDR == `TBOG_ADDR_GATE)
        g_ff <= WDATA;
      if (!BREAK_N)
        g_ff[0] <= 1'b0;
      if (CE && WR && ADDR == `TBOG_ADDR_CCER)
        c_ff <= WDATA[3:0];
      if (CE && WR && ADDR == `TBOG_ADDR_CTRL)
        p_ff <= WDATA[3];
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_rcr_upper: assert property (CE && RD && ADDR == `TBOG_ADDR_RCR |=> RDATA[15:8] == 8'h00)
    else $error("repeat register upper byte not zero");
  a_upd_pulse: assert property (REPEAT_UPDATE_EVENT |=> !REPEAT_UPDATE_EVENT)
    else $error("update pulse longer than one cycle");
  a_both_off: assert property ((ok && g_ff[0] && !g_ff[2] && !c_ff[0] && !c_ff[2]) [*2]
    |-> !OC_MAIN_OE && !OC_MAIN && !OC_COMPL_OE && !OC_COMPL)
    else $error("disabled pair not undriven at zero");
  a_one_main: assert property ((ok && g_ff[0] && c_ff[0] && !c_ff[2] && $stable(COMPARE_REFERENCE)) [*2]
    |-> OC_MAIN_OE && OC_MAIN == (COMPARE_REFERENCE ^ c_ff[1]) && OC_COMPL_OE == g_ff[2])
    else $error("single main output wrong");
  a_pair_both: assert property ((ok && g_ff[0] && c_ff[0] && c_ff[2] && $stable(COMPARE_REFERENCE)) [*3]
    |-> OC_MAIN_OE && OC_COMPL_OE && OC_MAIN == (COMPARE_REFERENCE ^ c_ff[1])
    && OC_COMPL == (!COMPARE_REFERENCE ^ c_ff[3]))
    else $error("complementary pair wrong");
  a_run_off: assert property ((ok && g_ff[0] && g_ff[2] && c_ff[0] && !c_ff[2]) [*2]
    |-> OC_COMPL_OE && OC_COMPL == c_ff[3])
    else $error("run off-state level wrong");
  a_idle_lvl: assert property ((ok && !g_ff[0] && (c_ff[0] || c_ff[2])) [*3]
    |-> OC_MAIN_OE == g_ff[1] && OC_COMPL_OE == g_ff[1] && OC_MAIN == g_ff[3] && OC_COMPL == g_ff[4])
    else $error("idle levels wrong");
  a_break_off: assert property (!BREAK_N && !g_ff[1] |-> ##2 !OC_MAIN_OE && !OC_COMPL_OE)
    else $error("break left outputs driven");
  a_cap_block: assert property (CE && g_ff[5] && !p_ff && !c_ff[0] && CAPTURE_IN |=> $stable(CAPTURE_VALUE))
    else $error("capture taken while disabled");
endmodule // tbog_timer_assertions
`default_nettype wire

//--- tbog_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbog_consts.vh"
module tbog_timer_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0, rd = 1'b0, ref_lvl = 1'b0, cap = 1'b0, brk_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rv, n, c1;
  wire [15:0] rdata, cap_val;
  wire om, ooe, oc, ocoe, upd, pin_h, pin_l;
  int n_errors = 0, checked = 0;
  time tl = 0;
  logic [7:0] am[4] = '{`TBOG_ADDR_CNT, `TBOG_ADDR_PSC, `TBOG_ADDR_ARR, `TBOG_ADDR_RCR};
  logic [15:0] gt[5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0005, 16'h000A};
  logic [3:0] ct[5] = '{4'h0, 4'h3, 4'h5, 4'h9, 4'h5};
  logic [3:0] et[5] = '{4'h0, 4'h8, 4'hE, 4'hF, 4'hE};
  tbog_timer dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .COMPARE_REFERENCE(ref_lvl), .CAPTURE_IN(cap), .BREAK_N(brk_n), .OC_MAIN(om),
    .OC_MAIN_OE(ooe), .OC_COMPL(oc), .OC_COMPL_OE(ocoe), .REPEAT_UPDATE_EVENT(upd), .CAPTURE_VALUE(cap_val));
  tbog_switch_model sw (.hi_lvl(om), .hi_oe(ooe), .lo_lvl(oc), .lo_oe(ocoe), .hi_gate(pin_h), .lo_gate(pin_l));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // cycles since the previous update pulse, bounded
  task automatic gap(output logic [15:0] c);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (upd !== 1'b1 && k < 400);
    c = 16'(($time - tl) / 10);
    tl = $time;
  endtask
  task automatic give_verdict;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    #300000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (am[i])
    begin
      rd_reg(am[i]);
      chk(rv, 16'h0000);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(am[i], 16'hA5C3);
      rd_reg(am[i]);
      chk(rv, 16'hA5C3);
    end
    wr_reg(`TBOG_ADDR_RCR, 16'h00C3);
    rd_reg(`TBOG_ADDR_RCR);
    chk(rv, 16'h00C3);
    wr_reg(`TBOG_ADDR_ARR, 16'h0003);
    wr_reg(`TBOG_ADDR_PSC, 16'h0001);
    wr_reg(`TBOG_ADDR_RCR, 16'h0001);
    wr_reg(`TBOG_ADDR_CTRL, 16'h0011);
    gap(n);
    gap(n);
    chk(n, 16'd16);
    wr_reg(`TBOG_ADDR_PSC, 16'h0002);
    wr_reg(`TBOG_ADDR_RCR, 16'h0000);
    gap(n);
    chk(n, 16'd16);
    gap(n);
    chk(n, 16'd12);
    wr_reg(`TBOG_ADDR_ARR, 16'h0000);
    rd_reg(`TBOG_ADDR_CNT);
    c1 = rv;
    repeat (20) @(posedge clk);
    rd_reg(`TBOG_ADDR_CNT);
    chk(rv, c1);
    wr_reg(`TBOG_ADDR_CTRL, 16'h0000);
    ref_lvl <= 1'b1;
    foreach (gt[i])
    begin
      wr_reg(`TBOG_ADDR_GATE, gt[i]);
      wr_reg(`TBOG_ADDR_CCER, {12'h000, ct[i]});
      repeat (4) @(negedge clk);
      chk({12'h000, ooe, om, ocoe, oc}, {12'h000, et[i]});
      chk({14'h0000, pin_h, pin_l}, {14'h0000, et[i][3] & et[i][2], et[i][1] & et[i][0]});
    end
    wr_reg(`TBOG_ADDR_GATE, 16'h0001);
    wr_reg(`TBOG_ADDR_CCER, 16'h0001);
    wr_reg(`TBOG_ADDR_CTRL, 16'h0008);
    wr_reg(`TBOG_ADDR_CCER, 16'h0005);
    repeat (4) @(negedge clk);
    chk({15'h0000, ocoe}, 16'h0000);
    wr_reg(`TBOG_ADDR_CTRL, 16'h0028);
    repeat (4) @(negedge clk);
    chk({15'h0000, ocoe}, 16'h0001);
    brk_n <= 1'b0;
    repeat (3) @(negedge clk);
    chk({14'h0000, ooe, ocoe}, 16'h0000);
    rd_reg(`TBOG_ADDR_GATE);
    chk({15'h0000, rv[0]}, 16'h0000);
    brk_n <= 1'b1;
    wr_reg(`TBOG_ADDR_CTRL, 16'h0000);
    wr_reg(`TBOG_ADDR_GATE, 16'h0020);
    for (int j = 0; j < 2; j++)
    begin
      wr_reg(`TBOG_ADDR_CCER, j == 0 ? 16'h0001 : 16'h0000);
      wr_reg(`TBOG_ADDR_CNT, j == 0 ? 16'h0077 : 16'h0099);
      @(posedge clk);
      cap <= 1'b1;
      @(posedge clk);
      cap <= 1'b0;
      repeat (2) @(negedge clk);
      chk(cap_val, 16'h0077);
    end
    // a write while the clock enable is low must be ignored
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`TBOG_ADDR_CNT, 16'h1234);
    ce <= 1'b1;
    rd_reg(`TBOG_ADDR_CNT);
    chk(rv, 16'h0099);
    give_verdict();
  end
endmodule // tbog_timer_bench
bind tbog_timer tbog_timer_assertions u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .COMPARE_REFERENCE(COMPARE_REFERENCE), .CAPTURE_IN(CAPTURE_IN),
  .BREAK_N(BREAK_N), .OC_MAIN(OC_MAIN), .OC_MAIN_OE(OC_MAIN_OE), .OC_COMPL(OC_COMPL),
  .OC_COMPL_OE(OC_COMPL_OE), .REPEAT_UPDATE_EVENT(REPEAT_UPDATE_EVENT), .CAPTURE_VALUE(CAPTURE_VALUE));
`default_nettype wire
